// *** rtl/flash_psram_pkg.sv ***
// shared constants and carrier types for the flash/psram pin controller
package flash_psram_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int TOP_DQ = 15;
  localparam int FLASH_ADDR_W = 20;
  localparam int BYTE_ADDR_W = 21;
  localparam int PSRAM_MSB_4M = 17;
  localparam int PSRAM_MSB_8M = 18;
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W = 8;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_TIME_NS = 20;
  localparam int ACCESS_TIME_NS = 80;
  localparam int HOLD_TIME_NS = 20;
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_RECOVER_NS = 100;
  localparam int SETUP_CYCLES = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVER_CYCLES = (RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic is_psram;
    logic is_write;
    logic byte_mode;
    logic [BYTE_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic psram_upper_lane_n;
    logic psram_lower_lane_n;
  } req_s;

  typedef struct packed {
    logic [FLASH_ADDR_W-1:0] addr;
    logic flash_bank_enable_n;
    logic psram_enable_low_active;
    logic psram_enable_high_active;
    logic flash_output_gate_n;
    logic psram_output_gate_n;
    logic flash_write_strobe_n;
    logic psram_write_strobe_n;
    logic flash_width_select;
    logic psram_upper_lane_n;
    logic psram_lower_lane_n;
    logic write_protect_n;
    logic reset_n;
  } pin_ctrl_s;

  typedef enum logic [2:0] {
    ST_RESET_PULSE,
    ST_RESET_WAIT,
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } ctrl_state_e;

endpackage

// *** rtl/pin_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module pin_sync
  import flash_psram_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg <= d_i;
      stable_reg <= meta_reg;
    end
  end

  assign q_o = stable_reg;

endmodule

// *** rtl/flash_psram_host.sv ***
// host-side pin controller for a combined flash and psram memory package
//
// Summary of operation
// - top data line is msb or byte address
// - flash active only with bank enable low
// - psram active with low enable low, high enable high
// - upper and lower lane controls enable bytes
// - twenty flash address bits, psram up to msb
// - psram msb is bit 17 or 18
`timescale 1ns/10ps
module flash_psram_host
  import flash_psram_pkg::*;
#(
  parameter int PSRAM_ADDR_MSB = PSRAM_MSB_4M,
  parameter bit SPLIT_CONTROLS = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire req_s req_i,
  output logic req_ready_o,
  input wire logic write_protect_i,
  input wire logic reset_req_i,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_data_o,
  output logic device_busy_o,
  output pin_ctrl_s pins_o,
  output logic [DATA_W-1:0] dq_o,
  output logic [DATA_W-1:0] dq_oe_o,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic ready_busy_od_i
);

  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  initial begin
    if (PSRAM_ADDR_MSB != PSRAM_MSB_4M && PSRAM_ADDR_MSB != PSRAM_MSB_8M) begin
      $error("flash_psram_host: PSRAM_ADDR_MSB must be 17 or 18");
    end
  end

  // ---------------------------------------------------------------------------
  // pin input synchronisation
  // ---------------------------------------------------------------------------
  logic [DATA_W:0] sync_q;
  logic [DATA_W-1:0] dq_sync;
  logic ready_sync;

  pin_sync #(
    .WIDTH(DATA_W + 1)
  ) u_pin_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({ready_busy_od_i, dq_i}),
    .q_o(sync_q)
  );

  assign dq_sync = sync_q[DATA_W-1:0];
  assign ready_sync = sync_q[DATA_W];

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  ctrl_state_e state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  req_s req_reg, req_next;
  pin_ctrl_s pins_reg, pins_next;
  logic [DATA_W-1:0] dq_reg, dq_next;
  logic [DATA_W-1:0] dq_oe_reg, dq_oe_next;
  logic req_ready_reg, req_ready_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [DATA_W-1:0] rsp_data_reg, rsp_data_next;
  logic busy_reg, busy_next;

  localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] RESET_PULSE_LAST = CNT_W'(RESET_PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] RESET_RECOVER_LAST = CNT_W'(RESET_RECOVER_CYCLES - 1);

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [FLASH_ADDR_W-1:0] pin_addr(input req_s r);
    logic [FLASH_ADDR_W-1:0] a;
    a = '0;
    if (r.is_psram) begin
      for (int i = 0; i < FLASH_ADDR_W; i++) begin
        a[i] = (i <= PSRAM_ADDR_MSB) ? r.addr[i] : 1'b0;
      end
    end else if (r.byte_mode) begin
      a = r.addr[BYTE_ADDR_W-1:1];
    end else begin
      a = r.addr[FLASH_ADDR_W-1:0];
    end
    return a;
  endfunction

  function automatic pin_ctrl_s idle_pins(input pin_ctrl_s p, input logic wp, input logic rst_n);
    pin_ctrl_s q;
    q = p;
    q.flash_bank_enable_n = 1'b1;
    q.psram_enable_low_active = 1'b1;
    q.psram_enable_high_active = 1'b0;
    q.flash_output_gate_n = 1'b1;
    q.psram_output_gate_n = 1'b1;
    q.flash_write_strobe_n = 1'b1;
    q.psram_write_strobe_n = 1'b1;
    q.psram_upper_lane_n = 1'b1;
    q.psram_lower_lane_n = 1'b1;
    q.write_protect_n = ~wp;
    q.reset_n = rst_n;
    return q;
  endfunction

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic rd_gate_n;
    logic wr_strobe_n;
    state_next = state_reg;
    cnt_next = cnt_reg + CNT_W'(1);
    req_next = req_reg;
    pins_next = pins_reg;
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    req_ready_next = 1'b0;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    busy_next = ~ready_sync;
    rd_gate_n = 1'b1;
    wr_strobe_n = 1'b1;
    pins_next.write_protect_n = ~write_protect_i;
    unique case (state_reg)
      ST_RESET_PULSE: begin
        pins_next = idle_pins(pins_reg, write_protect_i, 1'b0);
        dq_oe_next = '0;
        if (cnt_reg == RESET_PULSE_LAST) begin
          pins_next.reset_n = 1'b1;
          cnt_next = '0;
          state_next = ST_RESET_WAIT;
        end
      end
      ST_RESET_WAIT: begin
        if (cnt_reg == RESET_RECOVER_LAST) begin
          cnt_next = '0;
          req_ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        req_ready_next = 1'b1;
        cnt_next = '0;
        if (reset_req_i) begin
          req_ready_next = 1'b0;
          pins_next.reset_n = 1'b0;
          state_next = ST_RESET_PULSE;
        end else if (req_valid_i && req_ready_reg) begin
          req_ready_next = 1'b0;
          req_next = req_i;
          pins_next.addr = pin_addr(req_i);
          // at most one array selected at a time
          pins_next.flash_bank_enable_n = req_i.is_psram;
          pins_next.psram_enable_low_active = ~req_i.is_psram;
          pins_next.psram_enable_high_active = req_i.is_psram;
          if (req_i.is_psram) begin
            pins_next.psram_upper_lane_n = req_i.psram_upper_lane_n;
            pins_next.psram_lower_lane_n = req_i.psram_lower_lane_n;
          end else begin
            pins_next.flash_width_select = ~req_i.byte_mode;
          end
          dq_next = req_i.wdata;
          dq_oe_next = '0;
          if (!req_i.is_psram && req_i.byte_mode) begin
            dq_next[TOP_DQ] = req_i.addr[0];
            dq_oe_next[TOP_DQ] = 1'b1;
          end
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_reg == SETUP_LAST) begin
          cnt_next = '0;
          rd_gate_n = req_reg.is_write;
          wr_strobe_n = ~req_reg.is_write;
          if (req_reg.is_write) begin
            if (!req_reg.is_psram && req_reg.byte_mode) begin
              dq_oe_next[7:0] = '1;
            end else begin
              dq_oe_next = '1;
            end
          end
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        rd_gate_n = req_reg.is_write;
        wr_strobe_n = ~req_reg.is_write;
        if (cnt_reg == STROBE_LAST) begin
          cnt_next = '0;
          rd_gate_n = 1'b1;
          wr_strobe_n = 1'b1;
          if (!req_reg.is_write) begin
            rsp_data_next = dq_sync;
            if (!req_reg.is_psram && req_reg.byte_mode) begin
              rsp_data_next[DATA_W-1:8] = '0;
            end
          end
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt_reg == HOLD_LAST) begin
          cnt_next = '0;
          pins_next = idle_pins(pins_reg, write_protect_i, 1'b1);
          dq_oe_next = '0;
          rsp_valid_next = 1'b1;
          req_ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_RESET_PULSE;
      end
    endcase
    if (state_reg == ST_SETUP || state_reg == ST_STROBE) begin
      if (SPLIT_CONTROLS) begin
        pins_next.flash_output_gate_n = rd_gate_n | req_reg.is_psram;
        pins_next.psram_output_gate_n = rd_gate_n | ~req_reg.is_psram;
        pins_next.flash_write_strobe_n = wr_strobe_n | req_reg.is_psram;
        pins_next.psram_write_strobe_n = wr_strobe_n | ~req_reg.is_psram;
      end else begin
        pins_next.flash_output_gate_n = rd_gate_n;
        pins_next.psram_output_gate_n = rd_gate_n;
        pins_next.flash_write_strobe_n = wr_strobe_n;
        pins_next.psram_write_strobe_n = wr_strobe_n;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= ST_RESET_PULSE;
      cnt_reg <= '0;
      req_reg <= '0;
      pins_reg <= '{addr: '0, flash_bank_enable_n: 1'b1, psram_enable_low_active: 1'b1,
                    psram_enable_high_active: 1'b0, flash_output_gate_n: 1'b1,
                    psram_output_gate_n: 1'b1, flash_write_strobe_n: 1'b1,
                    psram_write_strobe_n: 1'b1, flash_width_select: 1'b1,
                    psram_upper_lane_n: 1'b1, psram_lower_lane_n: 1'b1,
                    write_protect_n: 1'b1, reset_n: 1'b0};
      dq_reg <= '0;
      dq_oe_reg <= '0;
      req_ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      req_reg <= req_next;
      pins_reg <= pins_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      req_ready_reg <= req_ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      busy_reg <= busy_next;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign req_ready_o = req_ready_reg;
  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_data_o = rsp_data_reg;
  assign device_busy_o = busy_reg;
  assign pins_o = pins_reg;
  assign dq_o = dq_reg;
  assign dq_oe_o = dq_oe_reg;

endmodule

// *** bench/flash_psram_dev_model.sv ***
// behavioural model of the combined flash and psram device
`timescale 1ns/10ps
module flash_psram_dev_model
  import flash_psram_pkg::*;
(
  input wire logic clk_i,
  input wire pin_ctrl_s pins_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic [DATA_W-1:0] dq_oe_o,
  output logic busy_pull_o
);
  logic [DATA_W-1:0] fmem [16];
  logic [DATA_W-1:0] pmem [16];
  logic fws_q, pws_q;
  logic [5:0] busy_cnt;
  wire logic f_on = !pins_i.flash_bank_enable_n;
  wire logic p_on = !pins_i.psram_enable_low_active && pins_i.psram_enable_high_active;
  wire logic [3:0] a = pins_i.addr[3:0];
  wire logic [DATA_W-1:0] lanes = {{8{!pins_i.psram_upper_lane_n}}, {8{!pins_i.psram_lower_lane_n}}};
  wire logic prot = !pins_i.write_protect_n && pins_i.addr < 20'h02000;
  // -------------------------------------------------------------------------
  // read drive
  // -------------------------------------------------------------------------
  always_comb begin
    dq_o = fmem[a];
    if (!pins_i.flash_width_select) begin
      dq_o = {8'h00, dq_i[TOP_DQ] ? fmem[a][15:8] : fmem[a][7:0]};
    end
    if (p_on) begin
      dq_o = pmem[a];
    end
    dq_oe_o = '0;
    if (f_on && !pins_i.flash_output_gate_n) begin
      dq_oe_o = pins_i.flash_width_select ? 16'hffff : 16'h00ff;
    end
    if (p_on && !pins_i.psram_output_gate_n) begin
      dq_oe_o = lanes;
    end
  end
  // -------------------------------------------------------------------------
  // writes and busy
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    fws_q <= pins_i.flash_write_strobe_n;
    pws_q <= pins_i.psram_write_strobe_n;
    if (busy_cnt != 6'h00) begin
      busy_cnt <= busy_cnt - 6'h01;
    end
    if (f_on && !fws_q && pins_i.flash_write_strobe_n && !prot) begin
      fmem[a] <= dq_i;
      busy_cnt <= 6'h1e;
    end
    if (p_on && !pws_q && pins_i.psram_write_strobe_n) begin
      pmem[a] <= (pmem[a] & ~lanes) | (dq_i & lanes);
    end
    if (!pins_i.reset_n) begin
      busy_cnt <= 6'h00;
    end
  end
  assign busy_pull_o = busy_cnt != 6'h00;
endmodule

// *** bench/flash_psram_host_asserts.sv ***
// concurrent checks on the pin controller ports
`timescale 1ns/10ps
module flash_psram_host_asserts
  import flash_psram_pkg::*;
#(
  parameter int PSRAM_ADDR_MSB = PSRAM_MSB_4M
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire req_s req_i,
  input wire logic req_ready_o,
  input wire logic reset_req_i,
  input wire logic rsp_valid_o,
  input wire pin_ctrl_s pins_o,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic [DATA_W-1:0] dq_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  wire logic take = req_valid_i && req_ready_o && !reset_req_i;
  wire logic take_f = take && !req_i.is_psram;
  wire logic take_p = take && req_i.is_psram;
  wire logic p_on = !pins_o.psram_enable_low_active && pins_o.psram_enable_high_active;
  sequence s_low;
    !pins_o.flash_write_strobe_n ##8 !pins_o.flash_write_strobe_n;
  endsequence
  sequence s_frame;
    pins_o.flash_write_strobe_n ##3 s_low ##3 pins_o.flash_write_strobe_n;
  endsequence
  sequence s_pulse;
    !pins_o.reset_n ##49 !pins_o.reset_n ##1 pins_o.reset_n;
  endsequence
  chk_no_dual_enable: assert property (!(!pins_o.flash_bank_enable_n && p_on))
    else $error("both arrays enabled");
  chk_flash_cycle: assert property (take_f |-> ##2 !pins_o.flash_bank_enable_n ##13 rsp_valid_o)
    else $error("flash cycle wrong");
  chk_psram_cycle: assert property (take_p |-> ##2 p_on && pins_o.flash_bank_enable_n ##13 rsp_valid_o)
    else $error("psram cycle wrong");
  chk_write_frame: assert property (take_f && req_i.is_write |-> s_frame)
    else $error("flash strobe frame wrong");
  chk_width_sel: assert property (take_f |-> ##2 pins_o.flash_width_select == !$past(req_i.byte_mode, 2))
    else $error("width select wrong");
  chk_byte_addr: assert property (take_f && req_i.byte_mode |-> ##4 dq_oe_o[TOP_DQ] && dq_o[TOP_DQ] == $past(req_i.addr[0], 4))
    else $error("byte address bit wrong");
  chk_lane_ctrl: assert property (take_p |-> ##2 {pins_o.psram_upper_lane_n, pins_o.psram_lower_lane_n} ==
    $past({req_i.psram_upper_lane_n, req_i.psram_lower_lane_n}, 2))
    else $error("lane controls wrong");
  chk_psram_addr: assert property (take_p |-> ##2 (pins_o.addr >> (PSRAM_ADDR_MSB + 1)) == 0)
    else $error("psram address too wide");
  chk_reset_pulse: assert property ($fell(reset_i) |-> s_pulse)
    else $error("reset pulse wrong");
  chk_req_reset: assert property (reset_req_i && req_ready_o |=> s_pulse)
    else $error("requested reset pulse wrong");
endmodule
bind flash_psram_host flash_psram_host_asserts #(.PSRAM_ADDR_MSB(PSRAM_ADDR_MSB)) u_flash_psram_host_asserts (
  .clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
  .reset_req_i(reset_req_i), .rsp_valid_o(rsp_valid_o), .pins_o(pins_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o));

// *** bench/flash_psram_pin_interface_tb.sv ***
// self-checking testbench for the flash/psram pin controller
`timescale 1ns/10ps
module flash_psram_pin_interface_tb;
  import flash_psram_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_valid_i = 1'b0;
  req_s req_i = '0;
  logic write_protect_i = 1'b0;
  logic reset_req_i = 1'b0;
  logic req_ready_o, rsp_valid_o, device_busy_o, busy_pull;
  logic tog = 1'b0;
  logic [DATA_W-1:0] rsp_data_o, dq_o, dq_oe_o, dev_dq, dev_oe, dq_bus, rd;
  pin_ctrl_s pins_o;
  int miscompares = 0;
  int checked = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) tog <= ~tog;
  // released lines show a changing pattern, busy line has a pull-up
  assign dq_bus = (dq_oe_o & dq_o) | (~dq_oe_o & dev_oe & dev_dq) | (~dq_oe_o & ~dev_oe & {8{tog, ~tog}});
  flash_psram_host u_flash_psram_host (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .write_protect_i(write_protect_i), .reset_req_i(reset_req_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .device_busy_o(device_busy_o), .pins_o(pins_o),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_bus), .ready_busy_od_i(!busy_pull));
  flash_psram_dev_model u_flash_psram_dev_model (.clk_i(clk_i), .pins_i(pins_o), .dq_i(dq_bus),
    .dq_o(dev_dq), .dq_oe_o(dev_oe), .busy_pull_o(busy_pull));
  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  task automatic cmp_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    cmp_data({15'h0000, got}, {15'h0000, exp}, what);
  endtask
  task automatic access(input logic p, input logic w, input logic b, input logic [BYTE_ADDR_W-1:0] ad,
      input logic [DATA_W-1:0] wd, input logic un, input logic ln);
    int n;
    n = 0;
    @(posedge clk_i);
    while (req_ready_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    req_i <= '{p, w, b, ad, wd, un, ln};
    req_valid_i <= 1'b1;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    rd = rsp_data_o;
    cmp_flag(n < 200, 1'b1, "access timeout");
  endtask
  task automatic expect_busy(input logic exp, input int cycles);
    repeat (cycles) @(posedge clk_i);
    cmp_flag(device_busy_o, exp, "busy flag");
  endtask
  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task automatic t_flash_rw();
    access(1'b0, 1'b1, 1'b0, 21'h001005, 16'h5a3c, 1'b1, 1'b1);
    expect_busy(1'b1, 6);
    expect_busy(1'b0, 40);
    access(1'b0, 1'b0, 1'b0, 21'h001005, 16'h0000, 1'b1, 1'b1);
    cmp_data(rd, 16'h5a3c, "flash word read");
  endtask
  task automatic t_protect();
    write_protect_i <= 1'b1;
    access(1'b0, 1'b1, 1'b0, 21'h001005, 16'h1111, 1'b1, 1'b1);
    expect_busy(1'b0, 6);
    access(1'b0, 1'b0, 1'b0, 21'h001005, 16'h0000, 1'b1, 1'b1);
    cmp_data(rd, 16'h5a3c, "protected write took effect");
    write_protect_i <= 1'b0;
    access(1'b0, 1'b1, 1'b0, 21'h001005, 16'hc3e1, 1'b1, 1'b1);
    expect_busy(1'b1, 6);
    access(1'b0, 1'b0, 1'b0, 21'h001005, 16'h0000, 1'b1, 1'b1);
    cmp_data(rd, 16'hc3e1, "unprotected write lost");
  endtask
  task automatic t_byte_read();
    access(1'b0, 1'b0, 1'b1, 21'h00200b, 16'h0000, 1'b1, 1'b1);
    cmp_data(rd, 16'h00c3, "byte read upper");
    access(1'b0, 1'b0, 1'b1, 21'h00200a, 16'h0000, 1'b1, 1'b1);
    cmp_data(rd, 16'h00e1, "byte read lower");
  endtask
  task automatic t_psram_lanes();
    access(1'b1, 1'b1, 1'b0, 21'h1c0002, 16'h1234, 1'b0, 1'b0);
    access(1'b1, 1'b1, 1'b0, 21'h000002, 16'habcd, 1'b0, 1'b1);
    access(1'b1, 1'b0, 1'b0, 21'h000002, 16'h0000, 1'b0, 1'b0);
    cmp_data(rd, 16'hab34, "psram lane write");
  endtask
  task automatic t_dev_reset();
    access(1'b0, 1'b1, 1'b0, 21'h004005, 16'h7e81, 1'b1, 1'b1);
    @(posedge clk_i);
    reset_req_i <= 1'b1;
    @(posedge clk_i);
    reset_req_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp_flag(pins_o.reset_n, 1'b0, "reset pin not driven");
    expect_busy(1'b0, 8);
    access(1'b0, 1'b0, 1'b0, 21'h004005, 16'h0000, 1'b1, 1'b1);
    cmp_data(rd, 16'h7e81, "read after reset");
  endtask
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    t_flash_rw();
    t_protect();
    t_byte_read();
    t_psram_lanes();
    t_dev_reset();
    final_report();
  end
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule
